// ==== include/dsra_pkg.sv ====
`default_nettype none
package dsra_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned SYS_CLK_HZ       = 50_000_000;
	localparam int unsigned SYS_CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
	// shortest level accepted by the anti-spike filter, a least time
	localparam int unsigned SPIKE_NS         = 50;
	localparam int unsigned SPIKE_CYCLES_RAW = (SPIKE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int unsigned SPIKE_CYCLES     = (SPIKE_CYCLES_RAW < 1) ? 1 : SPIKE_CYCLES_RAW;
	// data hold added after the bus clock falls, a least time
	localparam int unsigned HOLD_NS          = 100;
	localparam int unsigned HOLD_CYCLES_RAW  = (HOLD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int unsigned HOLD_CYCLES      = (HOLD_CYCLES_RAW < 1) ? 1 : HOLD_CYCLES_RAW;
	localparam logic [3:0]  SPIKE_LAST       = 4'(SPIKE_CYCLES - 1);
	localparam logic [3:0]  HOLD_LAST        = 4'(HOLD_CYCLES - 1);

	// ****************************************
	// framing and addressing
	// ****************************************
	localparam int unsigned IDX_W         = 6;
	localparam int unsigned REG_COUNT     = 64;
	localparam logic [2:0]  BIT_LAST      = 3'h7;
	localparam logic [5:0]  I2C_BASE_ADDR = 6'h2c;
	localparam int unsigned CMD_RW_POS    = 7;
	localparam int unsigned CMD_HOLD_POS  = 6;
	localparam logic [7:0]  REG_RESET_VAL = 8'h00;

	// ****************************************
	// i2c slave states
	// ****************************************
	typedef enum logic [3:0] {
		DSRA_I_IDLE,
		DSRA_I_ADDR,
		DSRA_I_AACK,
		DSRA_I_IDX,
		DSRA_I_IACK,
		DSRA_I_WR,
		DSRA_I_WACK,
		DSRA_I_RD,
		DSRA_I_RACK,
		DSRA_I_RNEXT
	} dsra_i2c_st_t;
endpackage
`default_nettype wire

// ==== rtl/dsra_sync.sv ====
`default_nettype none
module dsra_sync #(
	parameter int unsigned W = 4
) (
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] next_sync_out;

	// ****************************************
	// three stage flops plus an output flop per line, accept on agreement
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_line
			always_comb begin
				next_sync_out[g] = (stage2[g] == stage3[g]) ? stage3[g] : sync_out[g];
			end
		end
	endgenerate

	// register the chain
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			stage2   <= stage1;
			stage3   <= stage2;
			sync_out <= next_sync_out;
		end
	end
endmodule // dsra_sync
`default_nettype wire

// ==== rtl/dsra_regs.sv ====
`default_nettype none
module dsra_regs (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       wr_en,
	input  wire logic [5:0] wr_index,
	input  wire logic [7:0] wr_data,
	input  wire logic [5:0] rd_index,
	output logic      [7:0] rd_data,
	input  wire logic [5:0] user_index,
	output logic      [7:0] user_data
);
	logic [7:0] mem [dsra_pkg::REG_COUNT];

	// ****************************************
	// shared register set, one serial write port
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < dsra_pkg::REG_COUNT; i++) begin
				mem[i] <= dsra_pkg::REG_RESET_VAL;
			end
			user_data <= dsra_pkg::REG_RESET_VAL;
		end else begin
			if (wr_en) begin
				mem[wr_index] <= wr_data;
			end
			user_data <= mem[user_index];
		end
	end

	// serial read port sees the array directly
	assign rd_data = mem[rd_index];
endmodule // dsra_regs
`default_nettype wire

// ==== rtl/dsra_port.sv ====
// Notes on behaviour
// R1: chip-select high means I2C, low SPI
// R2: on I2C the block is slave only
// R3: acknowledge only the matching 7-bit address
// R4: address LSB follows the strap pin
// R5: I2C up to high-speed rate
// R6: selectable anti-spike filter and output delay
// R7: SPI three-wire and four-wire, up to 20MHz
// R8: half-duplex select, zero means full-duplex
// R9: host may block I2C on shared bus
// R10: 16 pulses per access, 8 per extra byte
// R11: bits start on clock falling edges
// R12: bit 0 direction, read drives from bit 8
// R13: bit 1 is hold flag or parity
// R14: hold flag one keeps the index
// R15: bits 2-7 hold the register index
// R16: bits 8-15 carry data MSB first
// R17: registers stay accessible in power-down
// R18: one register set behind both ports
// R19: chip-select high releases the data output
// R20: half-duplex drives reads on shared pin
// R21: auto-advance adds one, wraps at 64
`default_nettype none
module dsra_port (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       chip_select_pin,
	input  wire logic       serial_clock_pin,
	input  wire logic       shared_serial_data_pin_in,
	output logic            shared_serial_data_pin_out,
	output logic            shared_serial_data_pin_oe,
	input  wire logic       data_out_or_address_strap_pin_in,
	output logic            data_out_or_address_strap_pin_out,
	output logic            data_out_or_address_strap_pin_oe,
	input  wire logic       spi_half_duplex,
	input  wire logic       i2c_block,
	input  wire logic       parity_mode,
	input  wire logic       spike_filter_en,
	input  wire logic       hold_delay_en,
	output logic            parity_error,
	input  wire logic [5:0] user_index,
	output logic      [7:0] user_data
);
	// ****************************************
	// pin synchronisers and edge finders
	// ****************************************
	logic [3:0] pins_s;
	logic       cs_s, sclk_s, sdi_s, address_lsb_strap;
	logic       sclk_prev, next_sclk_prev;
	logic       sclk_rise, sclk_fall;
	logic       spi_sel, i2c_sel;

	dsra_sync #(.W(4)) u_sync (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.async_in ({data_out_or_address_strap_pin_in, shared_serial_data_pin_in,
		            serial_clock_pin, chip_select_pin}),
		.sync_out (pins_s)
	);

	assign cs_s              = pins_s[0];
	assign sclk_s            = pins_s[1];
	assign sdi_s             = pins_s[2];
	assign address_lsb_strap = pins_s[3]; // R4
	assign spi_sel           = ~cs_s; // R1
	assign i2c_sel           = cs_s & ~i2c_block; // R1 R9
	assign sclk_rise         = sclk_s & ~sclk_prev;
	assign sclk_fall         = ~sclk_s & sclk_prev; // R11

	always_comb begin
		next_sclk_prev = sclk_s;
	end

	// ****************************************
	// anti-spike filter on i2c clock and data
	// ****************************************
	logic [1:0] flt, next_flt, flt_prev, next_flt_prev;
	logic [3:0] spk_cnt [2];
	logic [3:0] next_spk_cnt [2];
	logic [1:0] flt_raw;
	assign flt_raw = {sdi_s, sclk_s};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_flt
			// a change passes only after it stays for the spike time
			always_comb begin
				next_spk_cnt[g] = 4'h0;
				next_flt[g]     = flt[g];
				if (!spike_filter_en) begin
					next_flt[g] = flt_raw[g]; // R6
				end else if (flt_raw[g] != flt[g]) begin
					if (spk_cnt[g] == dsra_pkg::SPIKE_LAST) begin
						next_flt[g] = flt_raw[g]; // R6
					end else begin
						next_spk_cnt[g] = spk_cnt[g] + 4'h1;
					end
				end
			end
		end
	endgenerate

	always_comb begin
		next_flt_prev = flt;
	end

	logic scl_f, sda_f, scl_rise_f, scl_fall_f, i2c_start, i2c_stop;
	assign scl_f      = flt[0];
	assign sda_f      = flt[1];
	assign scl_rise_f = scl_f & ~flt_prev[0]; // R5
	assign scl_fall_f = ~scl_f & flt_prev[0];
	assign i2c_start  = i2c_sel & scl_f & flt_prev[0] & flt_prev[1] & ~sda_f;
	assign i2c_stop   = i2c_sel & scl_f & flt_prev[0] & ~flt_prev[1] & sda_f;

	// ****************************************
	// shared register set
	// ****************************************
	logic       reg_we;
	logic [5:0] s_idx, i_idx;
	logic [5:0] reg_widx, reg_ridx;
	logic [7:0] reg_wdata, reg_rdata;
	logic       spi_we, i2c_we;
	logic [7:0] spi_wdata, i2c_wdata;

	// R17 R18: both ports write and read the same array, in any power mode
	assign reg_we    = spi_we | i2c_we;
	assign reg_widx  = spi_sel ? s_idx : i_idx;
	assign reg_wdata = spi_sel ? spi_wdata : i2c_wdata;
	assign reg_ridx  = spi_sel ? s_idx : i_idx;

	dsra_regs u_regs (
		.sys_clk    (sys_clk),
		.srst       (srst),
		.wr_en      (reg_we),
		.wr_index   (reg_widx),
		.wr_data    (reg_wdata),
		.rd_index   (reg_ridx),
		.rd_data    (reg_rdata),
		.user_index (user_index),
		.user_data  (user_data)
	);

	// ****************************************
	// spi slave
	// ****************************************
	logic       s_started, s_data, s_rw, s_hold, s_perr, s_rd_drv;
	logic [2:0] s_pos;
	logic [7:0] s_rx, s_tx;
	logic       next_s_started, next_s_data, next_s_rw, next_s_hold, next_s_perr, next_s_rd_drv;
	logic [2:0] next_s_pos;
	logic [7:0] next_s_rx, next_s_tx;
	logic [5:0] next_s_idx;
	logic [7:0] s_byte;

	assign s_byte = {s_rx[6:0], sdi_s};

	// falling edge starts a bit, rising edge samples it
	always_comb begin
		next_s_started = s_started;
		next_s_data    = s_data;
		next_s_rw      = s_rw;
		next_s_hold    = s_hold;
		next_s_perr    = s_perr;
		next_s_rd_drv  = s_rd_drv;
		next_s_pos     = s_pos;
		next_s_rx      = s_rx;
		next_s_tx      = s_tx;
		next_s_idx     = s_idx;
		spi_we         = 1'b0;
		spi_wdata      = s_byte;
		if (!spi_sel) begin
			next_s_started = 1'b0;
			next_s_data    = 1'b0;
			next_s_pos     = 3'h0;
			next_s_rd_drv  = 1'b0; // R19
			next_s_tx      = 8'h00;
		end else begin
			if (sclk_fall) begin
				next_s_started = 1'b1; // R11
				if (s_data && s_rw) begin
					next_s_rd_drv = 1'b1; // R12
					if (s_pos == 3'h0) begin
						next_s_tx = s_perr ? 8'h00 : reg_rdata; // R16
					end else begin
						next_s_tx = {s_tx[6:0], 1'b0};
					end
				end
			end
			if (sclk_rise && s_started) begin
				next_s_rx  = s_byte;
				next_s_pos = s_pos + 3'h1; // R10
				if (s_pos == dsra_pkg::BIT_LAST) begin
					if (!s_data) begin
						next_s_data = 1'b1;
						next_s_rw   = s_byte[dsra_pkg::CMD_RW_POS]; // R12
						next_s_hold = ~parity_mode & s_byte[dsra_pkg::CMD_HOLD_POS]; // R13
						next_s_perr = parity_mode & ~(^s_byte[6:0]); // R13
						next_s_idx  = s_byte[5:0]; // R15
					end else begin
						spi_we = ~s_rw & ~s_perr; // R16
						if (!s_hold) begin
							next_s_idx = s_idx + 6'h01; // R14 R21
						end
					end
				end
			end
		end
	end

	// ****************************************
	// i2c slave
	// ****************************************
	dsra_pkg::dsra_i2c_st_t i_st, next_i_st;
	logic [2:0] i_cnt, next_i_cnt;
	logic [7:0] i_sh, next_i_sh;
	logic [5:0] next_i_idx;
	logic       i_rw, next_i_rw, i_want, next_i_want;
	logic [7:0] i_byte;

	assign i_byte    = {i_sh[6:0], sda_f};
	assign i2c_wdata = i_byte;

	// R2: only ever answers, never drives the clock
	always_comb begin
		next_i_st   = i_st;
		next_i_cnt  = i_cnt;
		next_i_sh   = i_sh;
		next_i_idx  = i_idx;
		next_i_rw   = i_rw;
		next_i_want = i_want;
		i2c_we      = 1'b0;
		if (!i2c_sel || i2c_stop) begin
			next_i_st   = dsra_pkg::DSRA_I_IDLE;
			next_i_want = 1'b0;
		end else if (i2c_start) begin
			next_i_st   = dsra_pkg::DSRA_I_ADDR;
			next_i_cnt  = 3'h0;
			next_i_want = 1'b0;
		end else if (scl_rise_f) begin
			case (i_st)
				dsra_pkg::DSRA_I_ADDR, dsra_pkg::DSRA_I_IDX, dsra_pkg::DSRA_I_WR: begin
					next_i_sh  = i_byte;
					next_i_cnt = i_cnt + 3'h1;
					if (i_cnt == dsra_pkg::BIT_LAST) begin
						if (i_st == dsra_pkg::DSRA_I_ADDR) begin
							if (i_byte[7:1] == {dsra_pkg::I2C_BASE_ADDR, address_lsb_strap}) begin // R3 R4
								next_i_rw = i_byte[0];
								next_i_st = dsra_pkg::DSRA_I_AACK;
							end else begin
								next_i_st = dsra_pkg::DSRA_I_IDLE; // R3
							end
						end else if (i_st == dsra_pkg::DSRA_I_IDX) begin
							next_i_idx = i_byte[5:0];
							next_i_st  = dsra_pkg::DSRA_I_IACK;
						end else begin
							i2c_we     = 1'b1;
							next_i_idx = i_idx + 6'h01; // R21
							next_i_st  = dsra_pkg::DSRA_I_WACK;
						end
					end
				end
				dsra_pkg::DSRA_I_RD: begin
					next_i_cnt = i_cnt + 3'h1;
					if (i_cnt == dsra_pkg::BIT_LAST) begin
						next_i_idx = i_idx + 6'h01; // R21
						next_i_st  = dsra_pkg::DSRA_I_RACK;
					end
				end
				dsra_pkg::DSRA_I_RACK: begin
					next_i_st = sda_f ? dsra_pkg::DSRA_I_IDLE : dsra_pkg::DSRA_I_RNEXT;
				end
				default: begin
					next_i_st = i_st;
				end
			endcase
		end else if (scl_fall_f) begin
			case (i_st)
				dsra_pkg::DSRA_I_AACK, dsra_pkg::DSRA_I_IACK, dsra_pkg::DSRA_I_WACK: begin
					next_i_cnt = 3'h0;
					if (!i_want) begin
						next_i_want = 1'b1; // R3
					end else if (i_st == dsra_pkg::DSRA_I_AACK && i_rw) begin
						next_i_sh   = reg_rdata;
						next_i_want = ~reg_rdata[7];
						next_i_st   = dsra_pkg::DSRA_I_RD;
					end else begin
						next_i_want = 1'b0;
						next_i_st   = (i_st == dsra_pkg::DSRA_I_AACK) ? dsra_pkg::DSRA_I_IDX : dsra_pkg::DSRA_I_WR;
					end
				end
				dsra_pkg::DSRA_I_RD: begin
					next_i_sh   = {i_sh[6:0], 1'b0};
					next_i_want = ~i_sh[6];
				end
				dsra_pkg::DSRA_I_RACK: begin
					next_i_want = 1'b0;
				end
				dsra_pkg::DSRA_I_RNEXT: begin
					next_i_cnt  = 3'h0;
					next_i_sh   = reg_rdata;
					next_i_want = ~reg_rdata[7];
					next_i_st   = dsra_pkg::DSRA_I_RD;
				end
				default: begin
					next_i_st = i_st;
				end
			endcase
		end
	end

	// ****************************************
	// i2c data output delay for hold time
	// ****************************************
	logic       i_oe, next_i_oe;
	logic [3:0] hold_cnt, next_hold_cnt;

	always_comb begin
		next_i_oe     = i_oe;
		next_hold_cnt = 4'h0;
		if (i_want != i_oe) begin
			if (!hold_delay_en || hold_cnt == dsra_pkg::HOLD_LAST) begin
				next_i_oe = i_want; // R6
			end else begin
				next_hold_cnt = hold_cnt + 4'h1;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sclk_prev  <= 1'b0; // matches synchroniser reset, no false fall
			flt        <= 2'h3;
			flt_prev   <= 2'h3;
			spk_cnt[0] <= 4'h0;
			spk_cnt[1] <= 4'h0;
			s_started  <= 1'b0;
			s_data     <= 1'b0;
			s_rw       <= 1'b0;
			s_hold     <= 1'b0;
			s_perr     <= 1'b0;
			s_rd_drv   <= 1'b0;
			s_pos      <= 3'h0;
			s_rx       <= 8'h00;
			s_tx       <= 8'h00;
			s_idx      <= 6'h00;
			i_st       <= dsra_pkg::DSRA_I_IDLE;
			i_cnt      <= 3'h0;
			i_sh       <= 8'h00;
			i_idx      <= 6'h00;
			i_rw       <= 1'b0;
			i_want     <= 1'b0;
			i_oe       <= 1'b0;
			hold_cnt   <= 4'h0;
		end else begin
			sclk_prev  <= next_sclk_prev;
			flt        <= next_flt;
			flt_prev   <= next_flt_prev;
			spk_cnt[0] <= next_spk_cnt[0];
			spk_cnt[1] <= next_spk_cnt[1];
			s_started  <= next_s_started;
			s_data     <= next_s_data;
			s_rw       <= next_s_rw;
			s_hold     <= next_s_hold;
			s_perr     <= next_s_perr;
			s_rd_drv   <= next_s_rd_drv;
			s_pos      <= next_s_pos;
			s_rx       <= next_s_rx;
			s_tx       <= next_s_tx;
			s_idx      <= next_s_idx;
			i_st       <= next_i_st;
			i_cnt      <= next_i_cnt;
			i_sh       <= next_i_sh;
			i_idx      <= next_i_idx;
			i_rw       <= next_i_rw;
			i_want     <= next_i_want;
			i_oe       <= next_i_oe;
			hold_cnt   <= next_hold_cnt;
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	// R7 R8 R19 R20: four-wire reads use the separate pin, three-wire the shared one
	assign data_out_or_address_strap_pin_oe  = spi_sel & ~spi_half_duplex;
	assign data_out_or_address_strap_pin_out = s_rd_drv & s_tx[7];
	assign shared_serial_data_pin_oe  = spi_sel ? (spi_half_duplex & s_rd_drv) : (i2c_sel & i_oe);
	assign shared_serial_data_pin_out = spi_sel & s_tx[7];
	assign parity_error               = s_perr;

	// ****************************************
	// checks
	// ****************************************
	sequence spi_last_rise;
		sclk_rise && s_started && s_pos == dsra_pkg::BIT_LAST;
	endsequence

	cs_high_release_a: assert property (@(posedge sys_clk) disable iff (srst) // R19
		cs_s |-> !data_out_or_address_strap_pin_oe)
		else $error("separate data output driven while deselected");
	half_duplex_pin_a: assert property (@(posedge sys_clk) disable iff (srst) // R20
		(spi_sel && spi_half_duplex) |-> !data_out_or_address_strap_pin_oe)
		else $error("separate data output driven in three-wire mode");
	read_drive_start_a: assert property (@(posedge sys_clk) disable iff (srst) // R12
		$rose(s_rd_drv) |-> (s_data && s_rw && s_pos == 3'h0 && $past(sclk_fall)))
		else $error("read data driven outside start of bit 8");
	write_byte_end_a: assert property (@(posedge sys_clk) disable iff (srst) // R16
		spi_we |-> (spi_last_rise and s_data && !s_rw))
		else $error("register write not at end of a data byte");
	index_advance_a: assert property (@(posedge sys_clk) disable iff (srst) // R21
		(spi_last_rise and s_data && !s_hold && spi_sel) |=> s_idx == 6'($past(s_idx) + 6'h01))
		else $error("index did not advance by one");
	index_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // R14
		(spi_last_rise and s_data && s_hold) |=> s_idx == $past(s_idx))
		else $error("held index changed");
	parity_block_a: assert property (@(posedge sys_clk) disable iff (srst) // R13
		s_perr |-> !spi_we)
		else $error("write performed despite parity error");
	i2c_mode_idle_a: assert property (@(posedge sys_clk) disable iff (srst) // R1
		i2c_sel |=> !s_started && !s_rd_drv)
		else $error("spi logic active in i2c mode");
	addr_mismatch_a: assert property (@(posedge sys_clk) disable iff (srst) // R3
		(i_st == dsra_pkg::DSRA_I_ADDR && scl_rise_f && !i2c_start && !i2c_stop && i2c_sel
		 && i_cnt == dsra_pkg::BIT_LAST && i_byte[7:1] != {dsra_pkg::I2C_BASE_ADDR, address_lsb_strap})
		|=> i_st == dsra_pkg::DSRA_I_IDLE ##1 !i_want)
		else $error("acknowledged a foreign address");
endmodule // dsra_port
`default_nettype wire

// ==== rtl/unused_placeholder_none.sv ====
`default_nettype none
`default_nettype wire

// ==== test/dsra_host.sv ====
`default_nettype none
// ****************************************
// serial master standing in for the host
// ****************************************
module dsra_host (
	input  wire logic sys_clk,
	input  wire logic sda,
	input  wire logic sdo,
	output logic      cs,
	output logic      sclk,
	output logic      hen,
	output logic      hval
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle: deselected, clock high, data released
	initial begin
		cs = 1'b1;
		sclk = 1'b1;
		hen = 1'b0;
		hval = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// spi frame of n bits, msb first; clock idles high at select
	task automatic spi(input logic [39:0] tx, input int n, input logic hdx, output logic [39:0] rx);
		rx = '0;
		hen <= 1'b1;
		hval <= tx[39];
		wt(1);
		cs <= 1'b0;
		wt(6);
		for (int i = 0; i < n; i++) begin
			sclk <= 1'b0;
			if (hdx && tx[39] && i >= 8)
				hen <= 1'b0;
			hval <= tx[39-i];
			wt(4);
			sclk <= 1'b1;
			wt(4);
			rx = {rx[38:0], hdx ? sda : sdo};
		end
		wt(2);
		cs <= 1'b1;
		hen <= 1'b0;
		wt(6);
	endtask
	// open drain: a zero pulls low, a one releases; bus clock near 1.7 MHz
	// long low phase leaves room for the slave's filter and hold delay
	task automatic i2c_bit(input logic b, output logic r);
		hval <= 1'b0;
		hen <= ~b;
		wt(12);
		sclk <= 1'b1;
		wt(6);
		r = sda;
		wt(6);
		sclk <= 1'b0;
		wt(6);
	endtask
	task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
		logic r;
		for (int i = 8; i >= 0; i--) begin
			i2c_bit(tx[i], r);
			rx[i] = r;
		end
	endtask
	// start and repeated start: data falls while clock high
	task automatic i2c_start();
		hen <= 1'b0;
		wt(12);
		sclk <= 1'b1;
		wt(12);
		hen <= 1'b1;
		hval <= 1'b0;
		wt(12);
		sclk <= 1'b0;
		wt(6);
	endtask
	task automatic i2c_stop();
		hen <= 1'b1;
		hval <= 1'b0;
		wt(6);
		sclk <= 1'b1;
		wt(12);
		hen <= 1'b0;
		wt(12);
	endtask
endmodule // dsra_host
`default_nettype wire

// ==== test/tb_top.sv ====
`default_nettype none
// ****************************************
// bench top
// ****************************************
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, srst, spi_half_duplex, i2c_block, parity_mode, spike_filter_en, hold_delay_en, strap;
	logic cs, sclk, hen, hval, sda_out, sda_oe, sdo_out, sdo_oe, parity_error;
	logic [5:0] user_index, idx;
	logic [7:0] user_data, d;
	logic [7:0] mem [64];
	logic [39:0] rx;
	logic [8:0] r9;
	integer seed;
	int miscompares, checked, cycles;
	// wire levels: pull-up in i2c, inverse of last value when released in spi
	wire logic sda = cs ? ~((hen & ~hval) | (sda_oe & ~sda_out)) : (sda_oe ? sda_out : (hen ? hval : ~hval));
	wire logic sdo = sdo_oe ? sdo_out : strap;
	dsra_port u_dut (.sys_clk(sys_clk), .srst(srst), .chip_select_pin(cs), .serial_clock_pin(sclk),
		.shared_serial_data_pin_in(sda), .shared_serial_data_pin_out(sda_out),
		.shared_serial_data_pin_oe(sda_oe), .data_out_or_address_strap_pin_in(sdo),
		.data_out_or_address_strap_pin_out(sdo_out), .data_out_or_address_strap_pin_oe(sdo_oe),
		.spi_half_duplex(spi_half_duplex), .i2c_block(i2c_block), .parity_mode(parity_mode),
		.spike_filter_en(spike_filter_en), .hold_delay_en(hold_delay_en), .parity_error(parity_error),
		.user_index(user_index), .user_data(user_data));
	dsra_host u_host (.sys_clk(sys_clk), .sda(sda), .sdo(sdo), .cs(cs), .sclk(sclk), .hen(hen), .hval(hval));
	always #10 sys_clk = ~sys_clk;
	// hang guard and half-duplex output release watch
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			report_and_stop();
		end
		if (spi_half_duplex === 1'b1 && cs === 1'b0 && cycles > 100)
			cmp_bit(sdo_oe, 1'b0);
	end
	function automatic logic [5:0] nxt(input logic [5:0] i, input int b, input logic hold);
		return hold ? i : i + 6'(b);
	endfunction
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic chk_reg(input logic [5:0] i);
		user_index <= i;
		repeat (3) @(posedge sys_clk);
		cmp_byte(user_data, mem[i]);
	endtask
	// spi write; the shadow copy follows complete bytes only
	task automatic wr(input logic [7:0] cmd, input logic [31:0] dat, input int n, input logic eff);
		logic [39:0] r;
		u_host.spi({cmd, dat}, n, spi_half_duplex, r);
		for (int b = 0; b < (n - 8) / 8; b++)
			if (eff)
				mem[nxt(cmd[5:0], b, cmd[6] & ~parity_mode)] = dat[31-8*b -: 8];
	endtask
	task automatic i2c_tx(input logic [7:0] b, input logic exp_ack);
		u_host.i2c_byte({b, 1'b1}, r9);
		cmp_bit(r9[0], exp_ack);
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		srst = 1'b1;
		{spi_half_duplex, parity_mode, strap} = 3'h0;
		{i2c_block, spike_filter_en, hold_delay_en} = 3'h7;
		user_index = 6'h00;
		{seed, miscompares, checked, cycles} = {32'd94, 96'd0};
		foreach (mem[i])
			mem[i] = dsra_pkg::REG_RESET_VAL;
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk_reg(6'h3f);
		for (int k = 0; k < 6; k++) begin
			idx = 6'($random(seed));
			d = (k == 0) ? 8'hff : 8'($random(seed));
			wr({2'b00, idx}, {d, 24'h0}, 16, 1'b1);
			chk_reg(idx);
			u_host.spi({2'b10, idx, 32'h0}, 16, 1'b0, rx);
			cmp_byte(rx[7:0], mem[idx]);
			cmp_bit(sdo_oe, 1'b0);
		end
		wr(8'h3f, 32'h11223300, 32, 1'b1);
		chk_reg(6'h00);
		chk_reg(6'h01);
		u_host.spi({8'hbf, 32'h0}, 32, 1'b0, rx);
		cmp_byte(rx[23:16], mem[63]);
		cmp_byte(rx[7:0], mem[1]);
		wr(8'h4a, 32'($random(seed)), 24, 1'b1);
		chk_reg(6'h0a);
		chk_reg(6'h0b);
		wr(8'h14, 32'h5a000000, 12, 1'b1);
		chk_reg(6'h14);
		spi_half_duplex <= 1'b1;
		idx = 6'($random(seed));
		wr({2'b00, idx}, 32'($random(seed)), 16, 1'b1);
		u_host.spi({2'b11, idx, 32'h0}, 16, 1'b1, rx);
		cmp_byte(rx[7:0], mem[idx]);
		spi_half_duplex <= 1'b0;
		parity_mode <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			idx = 6'($random(seed));
			wr({1'b0, (k == 1) ^ (^idx), idx}, 32'($random(seed)), 16, k == 1);
			chk_reg(idx);
			cmp_bit(parity_error, k == 0);
		end
		parity_mode <= 1'b0;
		i2c_block <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			strap <= k[0];
			{spike_filter_en, hold_delay_en} <= 2'($random(seed));
			idx = 6'($random(seed));
			d = 8'($random(seed));
			u_host.i2c_start();
			i2c_tx({6'h2c, k[0], 1'b0}, 1'b0);
			i2c_tx({2'b00, idx}, 1'b0);
			i2c_tx(d, 1'b0);
			mem[idx] = d;
			u_host.i2c_start();
			i2c_tx({6'h2c, k[0], 1'b0}, 1'b0);
			i2c_tx({2'b00, idx}, 1'b0);
			u_host.i2c_start();
			i2c_tx({6'h2c, k[0], 1'b1}, 1'b0);
			u_host.i2c_byte(9'h1ff, r9);
			cmp_byte(r9[8:1], mem[idx]);
			u_host.i2c_stop();
			chk_reg(idx);
			u_host.i2c_start();
			i2c_tx({6'h2c, ~k[0], 1'b0}, 1'b1);
			u_host.i2c_stop();
		end
		i2c_block <= 1'b1;
		u_host.i2c_start();
		i2c_tx({6'h2c, strap, 1'b0}, 1'b1);
		u_host.i2c_stop();
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
